// ==== hdl/drc_pkg.sv ====
package drc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int QDEPTH = 4;
	localparam int QPTR_W = 2;
	localparam int QCNT_W = 3;
	localparam int BUF_DEPTH = 32;
	localparam int BPTR_W = 5;
	localparam int BCNT_W = 6;
	localparam int BND_W = 11;
	localparam int PAGE_W = 10;
	localparam int RTY_W = 33;
	localparam int TMR_W = 16;
	// Read commands of the parallel bus.
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
	localparam logic [3:0] BE_ALL_N = 4'h0;
	// Prefetch boundaries in DWORDs.
	localparam logic [10:0] BOUND_ONE = 11'h001;
	localparam logic [10:0] BOUND_LINE = 11'h010;
	localparam logic [10:0] BOUND_MULT = 11'h020;
	localparam logic [7:0] CLS_ZERO = 8'h00;
	localparam logic [7:0] CLS_16 = 8'h10;
	// Defaults used when a limit input is zero.
	localparam logic [32:0] RETRY_LIMIT_DFLT = 33'h001000000;
	localparam logic [15:0] DISCARD_DFLT = 16'h8000;

	// Captured delayed read request.
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be_n;
		logic prefetch;
	} drc_req_s;

	// Target bus response in one clock.
	typedef struct packed {
		logic data_valid;
		logic retry;
		logic disconnect;
		logic abort;
	} drc_rsp_s;

	typedef enum logic [1:0] {
		DRC_IDLE = 2'b00,
		DRC_ISSUE = 2'b01,
		DRC_READ = 2'b10,
		DRC_DONE = 2'b11
	} drc_state_e;
endpackage : drc_pkg

// ==== hdl/drc_engine.sv ====
`timescale 1ns/100ps
// How it works
// - Start read only at head, writes delivered
// - Replay captured address and command exactly
// - Non-prefetch drives captured byte enables next
// - Prefetch drives all byte enables low
// - Retried read is reissued until data/error
// - No reissue after data then termination
// - Count retries against limit, flag error
// - Primary error pin only when enabled
// - Target data goes into read buffer
// - Accept a DWORD every clock, no waits
// - Deliver when complete (prefetch also early), headed, ordered
// - Memory read commands alias when matching
// - Disconnect with final buffered DWORD
// - Early initiator end discards buffered data
// - Early prefetch take switches to flow-through
// - Flow ends at initiator, 4KB, or full
// - Empty flow disconnects, timer discards data
// - Discard early when other reads wait
// - Discard timer drops unclaimed completion
// - At most four outstanding delayed reads
// - Duplicate request is not queued twice
// - Back-to-back requests handled any cycle not serving
// - Non-flow prefetch stops at aligned boundary
module drc_engine
	import drc_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic init_req_valid_in,
	input wire drc_req_s init_req_in,
	input wire logic init_ready_in,
	input wire logic init_term_in,
	input wire drc_rsp_s tgt_rsp_in,
	input wire logic [31:0] tgt_data_in,
	input wire logic posted_writes_pending_in,
	input wire logic [7:0] cache_line_size_in,
	input wire logic [32:0] retry_limit_in,
	input wire logic [15:0] discard_limit_in,
	input wire logic serr_enable_in,
	output logic tgt_start_out,
	output logic [31:0] tgt_addr_out,
	output logic [3:0] tgt_cmd_out,
	output logic [3:0] tgt_be_n_out,
	output logic tgt_stop_out,
	output logic init_retry_out,
	output logic init_data_valid_out,
	output logic [31:0] init_data_out,
	output logic init_disc_out,
	output logic system_error_out,
	output logic primary_system_error_n_out
);

	////////////////////////////////////////////////////////////////////
	drc_state_e state_reg, state_next;
	drc_req_s q_mem_reg [QDEPTH];
	drc_req_s q_mem_next [QDEPTH];
	logic [QPTR_W-1:0] q_wr_reg, q_wr_next, q_rd_reg, q_rd_next;
	logic [QCNT_W-1:0] q_cnt_reg, q_cnt_next;
	logic [DATA_W-1:0] buf_reg [BUF_DEPTH];
	logic [DATA_W-1:0] buf_next [BUF_DEPTH];
	logic [BPTR_W-1:0] bw_reg, bw_next, br_reg, br_next;
	logic [BCNT_W-1:0] bc_reg, bc_next;
	logic [RTY_W-1:0] rty_reg, rty_next;
	logic [TMR_W-1:0] tmr_reg, tmr_next;
	logic [BND_W-1:0] rx_reg, rx_next, allow_reg, allow_next;
	logic [PAGE_W-1:0] page_reg, page_next;
	logic flow_reg, flow_next, serving_reg, serving_next;
	logic stalled_reg, stalled_next;
	logic start_next, stop_next, retry_next, dv_next, disc_next;
	logic [31:0] addr_next, data_next;
	logic [3:0] cmd_next, be_next;
	logic err_next, serr_n_next;
	drc_req_s head;
	logic hit_head, hit_any, push_q, drop, exhaust, b_push, b_pop;
	logic [BND_W-1:0] bound;
	logic [RTY_W-1:0] rty_lim;
	logic [TMR_W-1:0] tmr_lim;

	// Address and command compare with memory read aliasing.
	function automatic logic req_match(drc_req_s a, drc_req_s b);
		logic am;
		logic bm;
		am = (a.cmd == CMD_MEM_RD) || (a.cmd == CMD_MEM_RD_LINE) ||
			(a.cmd == CMD_MEM_RD_MULT);
		bm = (b.cmd == CMD_MEM_RD) || (b.cmd == CMD_MEM_RD_LINE) ||
			(b.cmd == CMD_MEM_RD_MULT);
		return (a.addr == b.addr) && ((a.cmd == b.cmd) || (am && bm));
	endfunction : req_match

	////////////////////////////////////////////////////////////////////
	// Head entry, limits and queue search.
	always_comb
	begin
		logic [QPTR_W-1:0] slot;
		logic cls_ok;
		slot = '0;
		head = q_mem_reg[q_rd_reg];
		rty_lim = (retry_limit_in == '0) ? RETRY_LIMIT_DFLT : retry_limit_in;
		tmr_lim = (discard_limit_in == '0) ? DISCARD_DFLT : discard_limit_in;
		cls_ok = (cache_line_size_in == CLS_ZERO) ||
			(cache_line_size_in == CLS_16);
		hit_head = init_req_valid_in && (q_cnt_reg != '0) &&
			req_match(init_req_in, head);
		hit_any = 1'b0;
		for (int i = 0; i < QDEPTH; i++)
		begin
			slot = q_rd_reg + QPTR_W'(i);
			if ((QCNT_W'(i) < q_cnt_reg) &&
				req_match(init_req_in, q_mem_reg[slot]))
				hit_any = init_req_valid_in;
		end
		// Aligned prefetch boundary for a non-flow read.
		if (!head.prefetch)
			bound = BOUND_ONE;
		else if (head.cmd == CMD_MEM_RD_MULT)
			bound = cls_ok ? BOUND_MULT : {2'h0, cache_line_size_in, 1'b0};
		else
			bound = cls_ok ? BOUND_LINE : {3'h0, cache_line_size_in};
	end

	////////////////////////////////////////////////////////////////////
	// Next state for the target read, buffer, queue and initiator side.
	always_comb
	begin
		state_next = state_reg;
		q_mem_next = q_mem_reg;
		q_wr_next = q_wr_reg;
		q_rd_next = q_rd_reg;
		buf_next = buf_reg;
		bw_next = bw_reg;
		br_next = br_reg;
		rty_next = rty_reg;
		tmr_next = tmr_reg;
		rx_next = rx_reg;
		allow_next = allow_reg;
		page_next = page_reg;
		flow_next = flow_reg;
		serving_next = serving_reg;
		stalled_next = stalled_reg;
		addr_next = tgt_addr_out;
		cmd_next = tgt_cmd_out;
		be_next = tgt_be_n_out;
		data_next = init_data_out;
		start_next = 1'b0;
		stop_next = 1'b0;
		retry_next = 1'b0;
		dv_next = 1'b0;
		disc_next = 1'b0;
		err_next = 1'b0;
		serr_n_next = 1'b1;
		push_q = 1'b0;
		drop = 1'b0;
		exhaust = 1'b0;
		b_push = 1'b0;
		b_pop = 1'b0;
		case (state_reg)
			DRC_IDLE:
			begin
				if ((q_cnt_reg != '0) && !posted_writes_pending_in)
				begin
					state_next = DRC_ISSUE;
					rty_next = '0;
					tmr_next = '0;
					flow_next = 1'b0;
					stalled_next = 1'b0;
				end
			end
			DRC_ISSUE:
			begin
				start_next = 1'b1;
				addr_next = head.addr;
				cmd_next = head.cmd;
				rx_next = '0;
				allow_next = bound - (head.addr[12:2] & (bound - 1'b1));
				page_next = head.addr[11:2];
				state_next = DRC_READ;
			end
			DRC_READ:
			begin
				// Byte enables follow the address phase by one cycle.
				be_next = head.prefetch ? BE_ALL_N : head.be_n;
				if (tgt_rsp_in.data_valid)
				begin
					b_push = 1'b1;
					rx_next = rx_reg + 1'b1;
					page_next = page_reg + 1'b1;
					if ((flow_reg && (page_next == '0)) ||
						(!flow_reg && (rx_next == allow_reg)) ||
						(bc_reg == BCNT_W'(BUF_DEPTH - 1) && !b_pop))
					begin
						stop_next = 1'b1;
						state_next = DRC_DONE;
					end
					else if (tgt_rsp_in.retry || tgt_rsp_in.disconnect)
						state_next = DRC_DONE;
				end
				else if (tgt_rsp_in.abort)
					drop = 1'b1;
				else if (tgt_rsp_in.retry || tgt_rsp_in.disconnect)
				begin
					if (rx_reg != '0)
						state_next = DRC_DONE;
					else if (rty_reg + 1'b1 >= rty_lim)
					begin
						exhaust = 1'b1;
						drop = 1'b1;
					end
					else
					begin
						rty_next = rty_reg + 1'b1;
						state_next = DRC_ISSUE;
					end
				end
			end
			DRC_DONE:
			begin
				if (!serving_reg)
					tmr_next = tmr_reg + 1'b1;
				if (!serving_reg && (tmr_reg == tmr_lim - 1'b1))
				begin
					drop = 1'b1;
					err_next = 1'b1;
					serr_n_next = !serr_enable_in;
				end
				if (stalled_reg && (q_cnt_reg > QCNT_W'(1)))
					drop = 1'b1;
			end
			default:
				state_next = DRC_IDLE;
		endcase
		// A stalled flow-through read still runs the discard timer.
		if ((state_reg == DRC_READ) && stalled_reg)
		begin
			tmr_next = tmr_reg + 1'b1;
			if ((tmr_reg == tmr_lim - 1'b1) || (q_cnt_reg > QCNT_W'(1)))
			begin
				drop = 1'b1;
				stop_next = 1'b1;
			end
		end
		if (exhaust)
		begin
			err_next = 1'b1;
			serr_n_next = !serr_enable_in;
		end
		// Initiator side: data phases of a claimed completion.
		if (serving_reg)
		begin
			if (init_term_in)
			begin
				serving_next = 1'b0;
				drop = 1'b1;
				stop_next = stop_next || (state_reg == DRC_READ);
			end
			else if (init_ready_in && (bc_reg != '0))
			begin
				b_pop = 1'b1;
				dv_next = 1'b1;
				data_next = buf_reg[br_reg];
				if ((bc_reg == BCNT_W'(1)) && !b_push)
				begin
					disc_next = 1'b1;
					serving_next = 1'b0;
					if (state_reg == DRC_DONE && !stalled_reg)
						drop = 1'b1;
					else if (state_reg == DRC_DONE)
						drop = 1'b1;
					else
					begin
						stalled_next = 1'b1;
						tmr_next = '0;
					end
				end
			end
		end
		else if (init_req_valid_in)
		begin
			if (hit_head && (bc_reg != '0) && !posted_writes_pending_in &&
				((state_reg == DRC_DONE) ||
				((state_reg == DRC_READ) && head.prefetch)))
			begin
				serving_next = 1'b1;
				stalled_next = 1'b0;
				tmr_next = '0;
				if (state_reg == DRC_READ)
					flow_next = 1'b1;
			end
			else
			begin
				retry_next = 1'b1;
				if (!hit_any && (q_cnt_reg < QCNT_W'(QDEPTH)))
				begin
					push_q = 1'b1;
					q_mem_next[q_wr_reg] = init_req_in;
					q_wr_next = q_wr_reg + 1'b1;
				end
			end
		end
		// Buffer pointers; a dropped entry empties the buffer.
		if (b_push && !drop)
		begin
			buf_next[bw_reg] = tgt_data_in;
			bw_next = bw_reg + 1'b1;
		end
		if (b_pop)
			br_next = br_reg + 1'b1;
		bc_next = bc_reg + BCNT_W'(b_push) - BCNT_W'(b_pop);
		if (drop)
		begin
			state_next = DRC_IDLE;
			q_rd_next = q_rd_reg + 1'b1;
			bw_next = '0;
			br_next = '0;
			bc_next = '0;
			flow_next = 1'b0;
			stalled_next = 1'b0;
			serving_next = 1'b0;
		end
		q_cnt_next = q_cnt_reg + QCNT_W'(push_q) - QCNT_W'(drop);
	end

	////////////////////////////////////////////////////////////////////
	// Register stage for all state and outputs.
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_reg <= DRC_IDLE;
			for (int i = 0; i < QDEPTH; i++)
				q_mem_reg[i] <= '0;
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_reg[i] <= '0;
			q_wr_reg <= '0;
			q_rd_reg <= '0;
			q_cnt_reg <= '0;
			bw_reg <= '0;
			br_reg <= '0;
			bc_reg <= '0;
			rty_reg <= '0;
			tmr_reg <= '0;
			rx_reg <= '0;
			allow_reg <= '0;
			page_reg <= '0;
			flow_reg <= 1'b0;
			serving_reg <= 1'b0;
			stalled_reg <= 1'b0;
			tgt_start_out <= 1'b0;
			tgt_addr_out <= '0;
			tgt_cmd_out <= '0;
			tgt_be_n_out <= '0;
			tgt_stop_out <= 1'b0;
			init_retry_out <= 1'b0;
			init_data_valid_out <= 1'b0;
			init_data_out <= '0;
			init_disc_out <= 1'b0;
			system_error_out <= 1'b0;
			primary_system_error_n_out <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			q_mem_reg <= q_mem_next;
			buf_reg <= buf_next;
			q_wr_reg <= q_wr_next;
			q_rd_reg <= q_rd_next;
			q_cnt_reg <= q_cnt_next;
			bw_reg <= bw_next;
			br_reg <= br_next;
			bc_reg <= bc_next;
			rty_reg <= rty_next;
			tmr_reg <= tmr_next;
			rx_reg <= rx_next;
			allow_reg <= allow_next;
			page_reg <= page_next;
			flow_reg <= flow_next;
			serving_reg <= serving_next;
			stalled_reg <= stalled_next;
			tgt_start_out <= start_next;
			tgt_addr_out <= addr_next;
			tgt_cmd_out <= cmd_next;
			tgt_be_n_out <= be_next;
			tgt_stop_out <= stop_next;
			init_retry_out <= retry_next;
			init_data_valid_out <= dv_next;
			init_data_out <= data_next;
			init_disc_out <= disc_next;
			system_error_out <= err_next;
			primary_system_error_n_out <= serr_n_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the engine's own behaviour.
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_launch;
		(state_reg == DRC_IDLE) ##1 (state_reg == DRC_ISSUE);
	endsequence

	sequence s_addr_then_data;
		(state_reg == DRC_READ) ##1 (state_reg == DRC_READ);
	endsequence

	AST_ORDER: assert property (s_launch |->
		$past(!posted_writes_pending_in))
		else $error("Read launched with posted writes pending.");
	AST_REPLAY: assert property (tgt_start_out |->
		(tgt_addr_out == head.addr) && (tgt_cmd_out == head.cmd))
		else $error("Replayed address or command differs.");
	AST_BE: assert property (s_addr_then_data |->
		tgt_be_n_out == (head.prefetch ? BE_ALL_N : head.be_n))
		else $error("Wrong byte enables on replayed read.");
	AST_RETRY: assert property ((state_reg == DRC_READ) &&
		!tgt_rsp_in.data_valid && !tgt_rsp_in.abort && tgt_rsp_in.retry &&
		(rx_reg == '0) && !exhaust && !drop |=> state_reg == DRC_ISSUE
		##1 tgt_start_out)
		else $error("Retried read not reissued.");
	AST_NO_REISSUE: assert property ((state_reg == DRC_DONE) |=>
		state_reg != DRC_ISSUE)
		else $error("Completed read was reissued.");
	AST_SERR: assert property (exhaust |=> system_error_out &&
		(primary_system_error_n_out == !$past(serr_enable_in)))
		else $error("Retry exhaustion error misreported.");
	AST_ACCEPT: assert property ((state_reg == DRC_READ) &&
		tgt_rsp_in.data_valid && !b_pop && !drop |=>
		bc_reg == $past(bc_reg) + 1'b1)
		else $error("Target DWORD not taken in its clock.");
	AST_DISC: assert property (init_data_valid_out &&
		(bc_reg == '0) && !$past(b_push) |-> init_disc_out)
		else $error("Final DWORD sent without disconnect.");
	AST_DEPTH: assert property (q_cnt_reg <= QCNT_W'(QDEPTH))
		else $error("More than four delayed reads held.");
	AST_DUP: assert property (!serving_reg && hit_any |=>
		q_cnt_reg <= $past(q_cnt_reg))
		else $error("Duplicate read entered the queue.");
endmodule : drc_engine

// ==== verif/drc_target_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Target bus model that answers the replayed reads of the engine.
module drc_target_model
	import drc_pkg::*;
(
	input wire logic clock_in,
	input wire logic start_in,
	input wire logic [31:0] addr_in,
	input wire logic stop_in,
	input wire logic [7:0] retries_in,
	input wire logic [3:0] gap_in,
	output drc_rsp_s rsp_out,
	output logic [31:0] data_out
);
	logic act = 1'b0;
	logic s;
	logic p;
	logic [3:0] w = 4'h0;
	logic [7:0] rc = 8'h00;
	logic [7:0] n = 8'h00;
	logic [31:0] a = 32'h0;

	// Lines start quiet.
	initial
	begin
		rsp_out = '0;
		data_out = 32'h0;
	end

	////////////////////////////////////////////////////////////////////
	// Samples at the edge and answers just after it. An idle data line
	// shows the inverse of its last value, so stale data never passes.
	always @(posedge clock_in)
	begin
		s = start_in;
		p = stop_in;
		#1;
		rsp_out = '0;
		data_out = ~data_out;
		if (s)
		begin
			act = 1'b1;
			n = 8'h00;
			w = gap_in;
			a = addr_in;
		end
		if (p)
			act = 1'b0;
		if (act && w != 4'h0)
			w = w - 4'h1;
		else if (act && rc < retries_in)
		begin
			rsp_out.retry = 1'b1;
			rc = rc + 8'h01;
			act = 1'b0;
		end
		else if (act)
		begin
			rsp_out.data_valid = 1'b1;
			data_out = a + {22'h0, n, 2'b00};
			n = n + 8'h01;
			rc = 8'h00;
		end
	end
endmodule : drc_target_model

// ==== verif/tb.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Self-checking bench for the delayed read engine.
module tb;
	import drc_pkg::*;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic req_valid = 1'b0;
	drc_req_s req = '0;
	logic ready = 1'b0;
	logic term = 1'b0;
	logic pend = 1'b0;
	logic serr_en = 1'b0;
	logic [15:0] dlim = 16'h0100;
	logic [7:0] retries = 8'h00;
	logic [3:0] gap = 4'h0;
	drc_rsp_s rsp;
	logic [31:0] tdata, taddr, idata, cap_addr;
	logic [3:0] tcmd, tbe, cap_cmd, cap_be;
	logic start, stop, iretry, ivalid, idisc, serr, perr_n;
	logic be_next = 1'b0;
	int fail_count = 0;
	int check_count = 0;
	int starts = 0;
	int serrs = 0;
	int perrs = 0;
	int stops = 0;

	// Free-running 100 MHz clock.
	always #5 clock_in = ~clock_in;

	drc_engine drc_engine_i (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.init_req_valid_in(req_valid),
		.init_req_in(req),
		.init_ready_in(ready),
		.init_term_in(term),
		.tgt_rsp_in(rsp),
		.tgt_data_in(tdata),
		.posted_writes_pending_in(pend),
		.cache_line_size_in(CLS_ZERO),
		.retry_limit_in(33'h000000004),
		.discard_limit_in(dlim),
		.serr_enable_in(serr_en),
		.tgt_start_out(start),
		.tgt_addr_out(taddr),
		.tgt_cmd_out(tcmd),
		.tgt_be_n_out(tbe),
		.tgt_stop_out(stop),
		.init_retry_out(iretry),
		.init_data_valid_out(ivalid),
		.init_data_out(idata),
		.init_disc_out(idisc),
		.system_error_out(serr),
		.primary_system_error_n_out(perr_n)
	);

	drc_target_model drc_target_model_i (
		.clock_in(clock_in),
		.start_in(start),
		.addr_in(taddr),
		.stop_in(stop),
		.retries_in(retries),
		.gap_in(gap),
		.rsp_out(rsp),
		.data_out(tdata)
	);

	// Counts replays and error pulses and keeps the last replay.
	always @(posedge clock_in)
	begin
		be_next <= start;
		if (start)
		begin
			starts++;
			cap_addr <= taddr;
			cap_cmd <= tcmd;
		end
		if (be_next)
			cap_be <= tbe;
		if (stop)
			stops++;
		if (serr)
			serrs++;
		if (!perr_n)
			perrs++;
	end

	////////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Lets n edges pass, then steps just past the last one.
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : step

	// One address phase; a new request is retried, a repeat is claimed.
	task automatic ask(input logic [31:0] a, input logic [3:0] c,
		input logic pf, input logic exp_retry);
		req = '{addr: a, cmd: c, be_n: 4'ha, prefetch: pf};
		req_valid = 1'b1;
		step(1);
		req_valid = 1'b0;
		check(iretry, exp_retry);
	endtask : ask

	// Two address phases back to back; valid stays high between them.
	task automatic ask_twice(input logic [31:0] a, input logic [3:0] c);
		req = '{addr: a, cmd: c, be_n: 4'ha, prefetch: 1'b0};
		req_valid = 1'b1;
		step(1);
		check(iretry, 33'h1);
		step(1);
		req_valid = 1'b0;
		check(iretry, 33'h1);
	endtask : ask_twice

	// Takes n DWORDs; ready is dropped once n data phases are asked for.
	task automatic take(input int n, input logic [31:0] a, input logic l);
		int i;
		int q;
		int t;
		i = 0;
		q = 0;
		t = 0;
		ready = 1'b1;
		while (i < n && t < 400)
		begin
			step(1);
			t++;
			if (ready)
				q++;
			if (q >= n)
				ready = 1'b0;
			if (ivalid === 1'b1)
			begin
				check(idata, a + 32'(4 * i));
				check(idisc, 33'(l && i == n - 1));
				i++;
			end
		end
		ready = 1'b0;
		check(33'(i), 33'(n));
	endtask : take

	////////////////////////////////////////////////////////////////////
	// Non-prefetch read held back by writes, with a duplicate request.
	task automatic t_nonpf;
		pend = 1'b1;
		ask_twice(32'h0000_0104, CMD_MEM_RD);
		step(10);
		check(33'(starts), 33'd0);
		pend = 1'b0;
		step(30);
		check(33'(starts), 33'd1);
		check(33'(stops), 33'd1);
		check(cap_addr, 32'h0000_0104);
		check(cap_cmd, CMD_MEM_RD);
		check(cap_be, 4'ha);
		ask(32'h0000_0104, CMD_MEM_RD, 1'b0, 1'b0);
		take(1, 32'h0000_0104, 1'b1);
		step(10);
		check(33'(starts), 33'd1);
	endtask : t_nonpf

	// Prefetch read to its boundary, repeated with an aliased command.
	task automatic t_pref(input logic [3:0] c, input int n);
		int s0;
		s0 = starts;
		ask(32'h0000_1000, c, 1'b1, 1'b1);
		step(60);
		check(33'(starts - s0), 33'd1);
		check(cap_be, BE_ALL_N);
		ask(32'h0000_1000, CMD_MEM_RD, 1'b1, 1'b0);
		take(n, 32'h0000_1000, 1'b1);
	endtask : t_pref

	// Target retries twice after a slow answer, then gives data.
	task automatic t_retry;
		int s0;
		s0 = starts;
		retries = 8'h02;
		gap = 4'h2;
		ask(32'h0000_0208, CMD_MEM_RD, 1'b0, 1'b1);
		step(60);
		check(33'(starts - s0), 33'd3);
		ask(32'h0000_0208, CMD_MEM_RD, 1'b0, 1'b0);
		take(1, 32'h0000_0208, 1'b1);
		retries = 8'h00;
		gap = 4'h0;
	endtask : t_retry

	// Target retries forever until the attempt limit is reached.
	task automatic t_limit(input logic en);
		int s0;
		int e0;
		int p0;
		s0 = starts;
		e0 = serrs;
		p0 = perrs;
		serr_en = en;
		retries = 8'hff;
		ask(32'h0000_0300, CMD_MEM_RD, 1'b0, 1'b1);
		step(60);
		check(33'(starts - s0), 33'd4);
		check(33'(serrs - e0), 33'd1);
		check(33'(perrs - p0), 33'(en));
		retries = 8'h00;
	endtask : t_limit

	// Early repeat streams through the buffer up to the 4KB boundary.
	task automatic t_flow;
		ask(32'h0000_2e00, CMD_MEM_RD_MULT, 1'b1, 1'b1);
		step(4);
		ask(32'h0000_2e00, CMD_MEM_RD_MULT, 1'b1, 1'b0);
		step(4);
		take(128, 32'h0000_2e00, 1'b1);
	endtask : t_flow

	// Early end discards data; an unclaimed completion times out.
	task automatic t_discard;
		int e0;
		ask(32'h0000_1400, CMD_MEM_RD_LINE, 1'b1, 1'b1);
		step(40);
		ask(32'h0000_1400, CMD_MEM_RD_LINE, 1'b1, 1'b0);
		take(2, 32'h0000_1400, 1'b0);
		term = 1'b1;
		step(1);
		term = 1'b0;
		dlim = 16'h0010;
		e0 = serrs;
		ask(32'h0000_1400, CMD_MEM_RD_LINE, 1'b1, 1'b1);
		step(70);
		check(33'(serrs - e0), 33'd1);
		ask(32'h0000_1400, CMD_MEM_RD_LINE, 1'b1, 1'b1);
	endtask : t_discard

	////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// Main sequence after a reset of 20 clocks.
	initial
	begin
		step(20);
		reset_n_in = 1'b1;
		check({start, iretry, ivalid, serr, perr_n}, 5'h01);
		t_nonpf();
		t_pref(CMD_MEM_RD_LINE, 16);
		t_pref(CMD_MEM_RD_MULT, 32);
		t_retry();
		t_limit(1'b0);
		t_limit(1'b1);
		t_flow();
		t_discard();
		report_and_stop();
	end

	// Cuts a hang short well after the tests should have finished.
	initial
	begin
		#50000;
		fail_count++;
		report_and_stop();
	end
endmodule : tb
